// ===== core/power_up_mode_sequencer.sv
// Purpose: Sequences release after power-on reset in one of three modes
// Assumes: rst is the on-chip power-on reset; pins are synchronised here
// Notes:   Emulation takes one serial bit per rising edge of the data clock
`timescale 1ns/100ps
module power_up_mode_sequencer #(
    parameter power_up_pkg::start_mode_e START_MODE =
        power_up_pkg::MODE_IMMEDIATE,
    parameter int unsigned HOLD_CYCLES  = power_up_pkg::HOLD_CYCLES,
    parameter int unsigned STREAM_BITS  = power_up_pkg::STREAM_BITS,
    parameter int unsigned INIT_CYCLES  = power_up_pkg::INIT_CYCLES,
    parameter bit          USE_INIT_OUT = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic supply_good,
    input  wire logic cfg_clk_pin,
    input  wire logic cfg_data_pin,
    input  wire logic configuration_complete_line_in,
    output logic      configuration_complete_line_out,
    output logic      configuration_complete_line_oe,
    output logic      init_complete_out,
    output logic      init_complete_oe,
    output logic      user_reset,
    output logic      user_run,
    output logic      outputs_enable
);
    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_HOLD,
        ST_RECEIVE,
        ST_INIT,
        ST_RUN
    } seq_state_e;

    typedef struct packed {
        seq_state_e             st;
        logic [1:0]             sync_supply;
        logic [1:0]             sync_clk;
        logic [1:0]             sync_data;
        logic [1:0]             sync_line;
        logic                   clk_prev;
        logic [31:0]            bit_count;
        logic [7:0]             settle;
        logic                   timer_start;
        power_up_pkg::od_drive_s done_pin;
        power_up_pkg::od_drive_s init_pin;
        logic                   user_reset;
        logic                   user_run;
        logic                   outputs_enable;
    } seq_s;

    seq_s        state_reg;
    seq_s        state_next;
    logic        timer_done;
    logic [31:0] timer_span;

    assign timer_span = (START_MODE == power_up_pkg::MODE_DELAYED)
                        ? HOLD_CYCLES[31:0] : INIT_CYCLES[31:0];

    cycle_timer #(
        .WIDTH (32)
    ) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (state_reg.timer_start),
        .span    (timer_span),
        .done    (timer_done)
    );

    always_comb begin
        state_next = state_reg;
        state_next.sync_supply = {state_reg.sync_supply[0], supply_good};
        state_next.sync_clk    = {state_reg.sync_clk[0], cfg_clk_pin};
        state_next.sync_data   = {state_reg.sync_data[0], cfg_data_pin};
        state_next.sync_line   = {state_reg.sync_line[0],
                                  configuration_complete_line_in};
        state_next.clk_prev    = state_reg.sync_clk[1];
        state_next.timer_start = 1'b0;
        case (state_reg.st)
            ST_SETTLE: begin
                if (!state_reg.sync_supply[1]) begin
                    state_next.settle = '0;
                end else if (state_reg.settle !=
                             power_up_pkg::SETTLE_CYCLES[7:0]) begin
                    state_next.settle = state_reg.settle + 8'h01;
                end else begin
                    state_next.outputs_enable = 1'b1;
                    case (START_MODE)
                        power_up_pkg::MODE_DELAYED: begin
                            state_next.done_pin.oe = 1'b1;
                            state_next.timer_start = 1'b1;
                            state_next.st          = ST_HOLD;
                        end
                        power_up_pkg::MODE_EMULATION: begin
                            state_next.done_pin.oe = 1'b1;
                            state_next.init_pin.oe = USE_INIT_OUT;
                            state_next.bit_count   = '0;
                            state_next.st          = ST_RECEIVE;
                        end
                        default: begin
                            state_next.done_pin.oe = 1'b0;
                            state_next.user_reset  = 1'b0;
                            state_next.user_run    = 1'b1;
                            state_next.st          = ST_RUN;
                        end
                    endcase
                end
            end
            ST_HOLD: begin
                if (timer_done && !state_reg.timer_start) begin
                    state_next.done_pin.oe = 1'b0;
                    state_next.user_reset  = 1'b0;
                    state_next.user_run    = 1'b1;
                    state_next.st          = ST_RUN;
                end
            end
            // count bits on data clock rise
            ST_RECEIVE: begin
                if (state_reg.sync_clk[1] && !state_reg.clk_prev) begin
                    state_next.bit_count = state_reg.bit_count + 32'h1;
                    if (state_reg.bit_count == STREAM_BITS[31:0] - 32'h1) begin
                        state_next.timer_start = 1'b1;
                        state_next.st          = ST_INIT;
                    end
                end
            end
            ST_INIT: begin
                state_next.done_pin.oe = 1'b0;
                if (timer_done && !state_reg.timer_start) begin
                    // run starts in the same cycle the init output is released
                    state_next.init_pin.oe = 1'b0;
                    state_next.user_reset  = 1'b0;
                    state_next.user_run    = 1'b1;
                    state_next.st          = ST_RUN;
                end
            end
            ST_RUN: begin
                state_next.user_run = 1'b1;
            end
            default: begin
                state_next.st = ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg            <= '0;
            state_reg.st         <= ST_SETTLE;
            state_reg.user_reset <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign configuration_complete_line_out = state_reg.done_pin.out;
    assign configuration_complete_line_oe  = state_reg.done_pin.oe;
    assign init_complete_out               = state_reg.init_pin.out;
    assign init_complete_oe                = state_reg.init_pin.oe;
    assign user_reset                      = state_reg.user_reset;
    assign user_run                        = state_reg.user_run;
    assign outputs_enable                  = state_reg.outputs_enable;
endmodule : power_up_mode_sequencer

// ===== core/power_up_pkg.sv
// Purpose: Constants and carriers for the power-up mode sequencer
// Assumes: 100 MHz clk_sys, asynchronous active-high rst from the on-chip POR
// Notes:   Start-up mode is chosen at build time
// How it works
// - Three start-up modes exist and one governs how the part becomes ready.
// - In immediate mode the power-on reset clears all state and the part runs.
// - In immediate mode the completion line floats as soon as reset ends.
// - Delayed mode adds a 50 ms reset hold after power-on reset.
// - During the delayed hold the completion line is driven low, then floats.
// - Immediate and delayed modes need no configuration data at all.
// - Emulation mode takes a full bitstream from the external source.
// - After the whole bitstream the part frees the line, then initialises.
// - With the init-complete output in use, operation starts in the cycle of its release.
// - No output is driven until operating conditions are reached.
package power_up_pkg;

    typedef enum logic [1:0] {
        MODE_IMMEDIATE,
        MODE_DELAYED,
        MODE_EMULATION
    } start_mode_e;

    // Extra reset hold of delayed mode
    localparam int unsigned HOLD_TIME_MS   = 50;
    localparam int unsigned CLK_FREQ_KHZ   = 100000;
    localparam int unsigned HOLD_CYCLES    = HOLD_TIME_MS * CLK_FREQ_KHZ;
    // Default emulated bitstream length in bits
    localparam int unsigned STREAM_BITS    = 1024;
    // Initialization phase length after the last bit
    localparam int unsigned INIT_CYCLES    = 16;
    // Supply-good settle length before any drive
    localparam int unsigned SETTLE_CYCLES  = 4;

    // Open-drain pin as two signals
    typedef struct packed {
        logic out;
        logic oe;
    } od_drive_s;

endpackage : power_up_pkg

// ===== core/cycle_timer.sv
// Purpose: Down counter that reports when a programmed span has elapsed
// Assumes: Same clock as its user
// Notes:   Loads on start, done is a level until next start
`timescale 1ns/100ps
module cycle_timer #(
    parameter int unsigned WIDTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] span,
    output logic                  done
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             run;
        logic             done;
    } timer_s;

    timer_s state_reg;
    timer_s state_next;

    always_comb begin
        state_next = state_reg;
        if (start) begin
            state_next.count = span;
            state_next.run   = 1'b1;
            state_next.done  = 1'b0;
        end else if (state_reg.run) begin
            if (state_reg.count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                state_next.run  = 1'b0;
                state_next.done = 1'b1;
            end else begin
                state_next.count = state_reg.count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign done = state_reg.done;
endmodule : cycle_timer

// ===== verification/power_up_props.sv
// Purpose: Port checker for the power-up mode sequencer
// Assumes: One clock domain, rst async active high
// Notes:   Bound to every sequencer instance
`timescale 1ns/100ps
module power_up_props #(
    parameter power_up_pkg::start_mode_e START_MODE =
        power_up_pkg::MODE_IMMEDIATE,
    parameter int unsigned HOLD_CYCLES = 20,
    parameter int unsigned STREAM_BITS = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic supply_good,
    input wire logic cfg_clk_pin,
    input wire logic configuration_complete_line_oe,
    input wire logic init_complete_oe,
    input wire logic user_reset,
    input wire logic user_run,
    input wire logic outputs_enable
);
    localparam bit IMM = START_MODE == power_up_pkg::MODE_IMMEDIATE;
    localparam bit DLY = START_MODE == power_up_pkg::MODE_DELAYED;
    localparam bit EMU = START_MODE == power_up_pkg::MODE_EMULATION;
    logic [31:0] held_reg;
    logic [31:0] bits_reg;
    logic        clk_prev_reg;
    logic        drive;
    logic        line_oe;
    assign line_oe = configuration_complete_line_oe;
    assign drive   = line_oe | init_complete_oe | outputs_enable;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Cycles held low, raw bit clock rises
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            held_reg     <= 32'h0;
            bits_reg     <= 32'h0;
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= cfg_clk_pin;
            if (line_oe) held_reg <= held_reg + 32'h1;
            if (cfg_clk_pin && !clk_prev_reg) bits_reg <= bits_reg + 32'h1;
        end
    end
    property p_quiet; drive |-> $past(supply_good, 2); endproperty
    a_quiet: assert property (p_quiet) else $error("early drive");
    property p_imm; IMM |-> !line_oe; endproperty
    a_imm: assert property (p_imm) else $error("line pulled");
    property p_run; user_run |-> !line_oe && !user_reset; endproperty
    a_run: assert property (p_run) else $error("run while held");
    property p_hold; DLY && $fell(line_oe) |-> held_reg >= HOLD_CYCLES;
    endproperty
    a_hold: assert property (p_hold) else $error("hold short");
    property p_hrst; DLY && line_oe |-> user_reset; endproperty
    a_hrst: assert property (p_hrst) else $error("hold not reset");
    property p_bits; EMU && $fell(line_oe) |-> bits_reg >= STREAM_BITS;
    endproperty
    a_bits: assert property (p_bits) else $error("early release");
    property p_init; user_run |-> !init_complete_oe; endproperty
    a_init: assert property (p_init) else $error("init held");
    property p_stay; user_run |=> user_run; endproperty
    a_stay: assert property (p_stay) else $error("run dropped");
    c_imm: cover property (IMM && $rose(user_run));
    c_dly: cover property (DLY && $fell(line_oe));
    c_emu: cover property (EMU && $rose(user_run));
endmodule : power_up_props
bind power_up_mode_sequencer power_up_props #(
    .START_MODE(START_MODE), .HOLD_CYCLES(HOLD_CYCLES),
    .STREAM_BITS(STREAM_BITS)
) u_props (
    .clk_sys, .rst, .supply_good, .cfg_clk_pin,
    .configuration_complete_line_oe, .init_complete_oe,
    .user_reset, .user_run, .outputs_enable
);

// ===== verification/cfg_source.sv
// Purpose: Configuration source and host for emulation mode
// Assumes: Bit clock half period of at least 3 clk_sys cycles
// Notes:   Bit clock rests low outside a frame
`timescale 1ns/100ps
module cfg_source (
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [15:0] nbits,
    input  wire logic [2:0]  half,
    input  wire logic        line,
    output logic             cfg_clk,
    output logic             cfg_data,
    output logic [15:0]      sent,
    output logic             host_ready
);
    logic [2:0] ph;
    assign host_ready = line;
    initial begin
        cfg_clk = 1'b0;
        cfg_data = 1'b0;
        sent = 16'h0;
        ph = 3'h0;
    end
    // whole stream sent, idle data churns
    // Frame starts only once the device pulls the line low
    always @(posedge clk_sys) begin
        if (!go || (sent >= nbits && !cfg_clk)
                || (sent == 16'h0 && line && !cfg_clk)) begin
            ph <= 3'h0;
            cfg_clk <= 1'b0;
            cfg_data <= ~cfg_data;
            if (!go) sent <= 16'h0;
        end else if (ph + 3'h1 < half) begin
            ph <= ph + 3'h1;
        end else begin
            ph <= 3'h0;
            cfg_clk <= ~cfg_clk;
            if (cfg_clk) cfg_data <= sent[1] ^ ~cfg_data;
            if (!cfg_clk) sent <= sent + 16'h1;
        end
    end
endmodule : cfg_source

// ===== verification/power_up_mode_sequencer_test.sv
// Purpose: Self-checking run of all three start-up modes
// Assumes: Shortened hold and stream lengths
// Notes:   Second round resets mid-run and sends surplus bits
`timescale 1ns/100ps
module power_up_mode_sequencer_test;
    localparam int unsigned HOLD_S = 20;
    localparam int unsigned BITS_S = 8;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        supply_good = 1'b0;
    logic        go = 1'b0;
    logic [2:0]  half = 3'h3;
    logic [15:0] nbits = 16'h0;
    logic [15:0] sent;
    logic        cfg_clk;
    logic        cfg_data;
    logic        ready;
    logic [2:0]  run, rstu, oe, ioe, lo, oen, line;
    logic [31:0] seed = 32'hf8779c44;
    int          mismatches = 0;
    int          n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    for (genvar m = 0; m < 3; m++) begin : g_mode
        assign line[m] = oe[m] ? lo[m] : 1'b1;
        power_up_mode_sequencer #(
            .START_MODE(power_up_pkg::start_mode_e'(m)),
            .HOLD_CYCLES(HOLD_S), .STREAM_BITS(BITS_S)
        ) dut (
            .clk_sys(clk_sys), .rst(rst), .supply_good(supply_good),
            .cfg_clk_pin(m == 2 ? cfg_clk : 1'b0),
            .cfg_data_pin(cfg_data),
            .configuration_complete_line_in(line[m]),
            .configuration_complete_line_out(lo[m]),
            .configuration_complete_line_oe(oe[m]),
            .init_complete_out(), .init_complete_oe(ioe[m]),
            .user_reset(rstu[m]), .user_run(run[m]),
            .outputs_enable(oen[m])
        );
    end
    cfg_source src (
        .clk_sys(clk_sys), .go(go), .nbits(nbits), .half(half),
        .line(line[2]), .cfg_clk(cfg_clk), .cfg_data(cfg_data),
        .sent(sent), .host_ready(ready)
    );
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic in_span(int n, int a, int b);
        return n >= a && n <= b;
    endfunction : in_span
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic power_round(input logic [15:0] bits);
        int held;
        int gap;
        int t;
        held = 0;
        gap = 0;
        @(posedge clk_sys);
        rst <= 1'b1;
        supply_good <= 1'b0;
        go <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        nbits <= bits;
        half <= 3'h3 + 3'(rnd() % 4);
        repeat (2 + rnd() % 6) begin
            @(negedge clk_sys);
            check({1'b0, run, oe, ioe, oen, rstu}, 16'h0007);
            @(posedge clk_sys);
        end
        supply_good <= 1'b1;
        go <= 1'b1;
        for (t = 0; t < 400 && run !== 3'b111; t++) begin
            @(negedge clk_sys);
            held = held + int'(oe[1] === 1'b1);
            gap = gap + int'(sent >= BITS_S && !oe[2] && !run[2]);
            check(16'(oe[0]), 16'h0);
            check(16'(rstu[1] | !oe[1]), 16'h1);
            check(16'(ioe[2] | !oe[2]), 16'h1);
            if (sent < BITS_S) check(16'(run[2]), 16'h0);
        end
        if (t == 400) begin
            mismatches++;
        end else begin
            check({13'h0, run}, 16'h7);
            check({13'h0, oe | ioe}, 16'h0);
            check({10'h0, oen, rstu}, 16'h0038);
            check({13'h0, line}, 16'h7);
            check(16'(ready), 16'h1);
            check(16'(in_span(held, HOLD_S, HOLD_S + 4)), 16'h1);
            check(16'(gap >= power_up_pkg::INIT_CYCLES), 16'h1);
        end
    endtask : power_round
    initial begin
        power_round(16'(BITS_S));
        power_round(16'(BITS_S + 3));
        report_and_stop();
    end
endmodule : power_up_mode_sequencer_test
